// ### src/sfsir_top.sv
// Serial port data, status, prescale and interrupt mask registers.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module sfsir_top (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESET_N,
    // Register port.
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Frame settings held elsewhere.
    input wire logic [7:0] SERIAL_CLOCK_RATE_FACTOR,
    input wire logic [3:0] FRAME_BITS_M1,
    // Shifter link.
    output sfsir_pkg::sfsir_tx_word_t TX_WORD,
    input wire logic TX_TAKE,
    input wire sfsir_pkg::sfsir_rx_frame_t RX_FRAME,
    input wire logic SHIFT_ACTIVE,
    output logic BIT_TICK,
    // Interrupt.
    output logic INTR
);
    import sfsir_pkg::*;

    sfsir_st_t s;
    sfsir_st_t next_s;

    logic wr_data;
    logic rd_data;
    logic [DW-1:0] txq_dout;
    logic [DW-1:0] rxq_dout;
    logic [CNT_W-1:0] txq_count;
    logic [CNT_W-1:0] rxq_count;
    logic txq_push;
    logic txq_pop;
    logic bypass;
    logic hold_free;
    logic tx_queue_empty;
    logic tx_queue_not_full;
    logic rx_queue_not_empty;
    logic rx_queue_full;
    logic link_active;
    logic [4:0] status;
    logic [3:0] raw;
    logic overrun_set;
    logic timeout_set;
    logic [DW-1:0] rd_mask;

    // Register strobes that reach the data queues.
    assign wr_data = WR && (ADDR == ADDR_DATA);
    assign rd_data = RD && (ADDR == ADDR_DATA);

    // The hold stage can take a word when empty or being taken.
    assign hold_free = !s.tx_out.valid || TX_TAKE;
    // An empty path hands the written word straight to the shifter.
    assign bypass = wr_data && (txq_count == '0) && hold_free;
    // Writes are dropped when the queue is full.
    assign txq_push = wr_data && tx_queue_not_full && !bypass;
    assign txq_pop = hold_free && (txq_count != '0);

    // Transmit queue.
    sfsir_queue u_txq (
        .clk(MCLK),
        .rst_n(RESET_N),
        .push(txq_push),
        .din(WDATA[DW-1:0]),
        .pop(txq_pop),
        .dout(txq_dout),
        .count(txq_count)
    );

    // Receive queue; a frame arriving when full replaces the newest.
    sfsir_queue u_rxq (
        .clk(MCLK),
        .rst_n(RESET_N),
        .push(RX_FRAME.strobe),
        .din(RX_FRAME.data),
        .pop(rd_data),
        .dout(rxq_dout),
        .count(rxq_count)
    );

    // Bit clock enable from the prescaler and rate factor.
    sfsir_bitclk u_bitclk (
        .clk(MCLK),
        .rst_n(RESET_N),
        .prescale_divisor(s.prescale_divisor),
        .serial_clock_rate_factor(SERIAL_CLOCK_RATE_FACTOR),
        .tick(BIT_TICK)
    );

    // Status flags; the hold stage counts toward the transmit empty flag but not the not-full flag.
    assign tx_queue_empty = (txq_count == '0) && !s.tx_out.valid;
    assign tx_queue_not_full = (txq_count != QUEUE_FULL);
    assign rx_queue_not_empty = (rxq_count != '0);
    assign rx_queue_full = (rxq_count == QUEUE_FULL);
    assign link_active = SHIFT_ACTIVE || !tx_queue_empty;
    assign status = {link_active, rx_queue_full, rx_queue_not_empty,
        tx_queue_not_full, tx_queue_empty};

    // Sticky event sources.
    assign overrun_set = RX_FRAME.strobe && rx_queue_full && !rd_data;
    assign timeout_set = BIT_TICK && rx_queue_not_empty && !rd_data
        && (s.to_cnt == TIMEOUT_BITS - 6'h01);

    // Raw conditions, independent of the mask.
    always_comb begin
        raw = '0;
        raw[IRQ_OVR] = s.overrun;
        raw[IRQ_TMO] = s.rx_timeout;
        raw[IRQ_RXH] = (rxq_count >= QUEUE_HALF);
        raw[IRQ_TXH] = (txq_count <= QUEUE_HALF);
    end

    // Received word mask for the configured frame length.
    assign rd_mask = 16'hffff >> (4'hf - FRAME_BITS_M1);

    // Next state: register writes, sticky flags, hold stage, read data.
    always_comb begin
        next_s = s;
        next_s.rdata = '0;
        // Hold stage toward the shifter.
        if (bypass) begin
            next_s.tx_out.data = WDATA[DW-1:0];
            next_s.tx_out.valid = 1'b1;
        end else if (txq_pop) begin
            next_s.tx_out.data = txq_dout;
            next_s.tx_out.valid = 1'b1;
        end else if (TX_TAKE) begin
            next_s.tx_out.valid = 1'b0;
        end
        // Time-out counter in bit periods, reset by a read or emptiness.
        if (!rx_queue_not_empty || rd_data) begin
            next_s.to_cnt = '0;
        end else if (BIT_TICK && s.to_cnt != TIMEOUT_BITS) begin
            next_s.to_cnt = s.to_cnt + 6'h01;
        end
        // Writes; the status and raw views ignore them.
        if (WR && ADDR == ADDR_PRESCALE) begin
            next_s.prescale_divisor = WDATA[7:0] & PRESCALE_MASK;
        end else if (WR && ADDR == ADDR_MASK) begin
            next_s.irq_mask = WDATA[3:0];
        end else if (WR && ADDR == ADDR_CLEAR) begin
            if (WDATA[IRQ_OVR]) begin
                next_s.overrun = 1'b0;
            end
            if (WDATA[IRQ_TMO]) begin
                next_s.rx_timeout = 1'b0;
            end
        end
        // A new event wins over a clear in the same cycle.
        if (overrun_set) begin
            next_s.overrun = 1'b1;
        end
        if (timeout_set) begin
            next_s.rx_timeout = 1'b1;
        end
        // Read data, valid in the cycle after the strobe only.
        if (RD && ADDR == ADDR_DATA) begin
            next_s.rdata[DW-1:0] = rxq_dout & rd_mask;
        end else if (RD && ADDR == ADDR_STATUS) begin
            next_s.rdata[4:0] = status;
        end else if (RD && ADDR == ADDR_PRESCALE) begin
            next_s.rdata[7:0] = s.prescale_divisor;
        end else if (RD && ADDR == ADDR_MASK) begin
            next_s.rdata[3:0] = s.irq_mask;
        end else if (RD && ADDR == ADDR_RAW) begin
            next_s.rdata[3:0] = raw;
        end else if (RD && ADDR == ADDR_MASKED) begin
            next_s.rdata[3:0] = raw & s.irq_mask;
        end
        // Interrupt line: any enabled raw condition.
        next_s.intr = |(raw & s.irq_mask);
    end

    // State register.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s.prescale_divisor <= PRESCALE_RESET;
            s.irq_mask <= MASK_RESET;
            s.overrun <= 1'b0;
            s.rx_timeout <= 1'b0;
            s.to_cnt <= '0;
            s.tx_out.data <= DATA_RESET;
            s.tx_out.valid <= 1'b0;
            s.rdata <= '0;
            s.intr <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    assign RDATA = s.rdata;
    assign TX_WORD = s.tx_out;
    assign INTR = s.intr;

    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);

    // A word written into an empty idle path is offered next cycle.
    direct_start_a: assert property (
        wr_data && txq_count == '0 && !s.tx_out.valid
        |=> TX_WORD.valid && TX_WORD.data == $past(WDATA[DW-1:0]))
        else $error("Written word not offered at once.");

    // Received data reads with the unused upper bits cleared.
    rx_justify_a: assert property (
        rd_data |=> (RDATA & ~{16'h0000, $past(rd_mask)}) == '0)
        else $error("Received data not right-justified.");

    // The empty flag follows the transmit queue level and the hold stage.
    tx_empty_flag_a: assert property (
        RD && ADDR == ADDR_STATUS
        |=> RDATA[ST_TXE] == ($past(txq_count) == '0
            && !$past(s.tx_out.valid)))
        else $error("Transmit empty flag wrong.");

    // The not-full and receive flags follow the queue levels.
    queue_flags_a: assert property (
        RD && ADDR == ADDR_STATUS
        |=> RDATA[ST_TXNF] == ($past(txq_count) != QUEUE_FULL)
            && RDATA[ST_RXNE] == ($past(rxq_count) != '0)
            && RDATA[ST_RXF] == ($past(rxq_count) == QUEUE_FULL))
        else $error("Queue flags wrong.");

    // Busy shows whenever the shifter runs.
    busy_flag_a: assert property (
        RD && ADDR == ADDR_STATUS && SHIFT_ACTIVE |=> RDATA[ST_ACT])
        else $error("Busy flag missing while shifting.");

    // Reserved status bits read as zero.
    status_reserved_a: assert property (
        RD && ADDR == ADDR_STATUS |=> RDATA[31:5] == '0)
        else $error("Reserved status bits set.");

    // The divisor always holds an even value.
    prescale_even_a: assert property (
        !s.prescale_divisor[0]) else $error("Odd prescale divisor.");

    // A frame into a full receive queue raises overrun.
    overrun_raise_a: assert property (
        RX_FRAME.strobe && rxq_count == QUEUE_FULL && !rd_data
        |=> s.overrun) else $error("Overrun not flagged.");

    // Thirty-two unread bit periods raise the time-out.
    timeout_raise_a: assert property (
        $rose(s.rx_timeout) |-> $past(s.to_cnt) == TIMEOUT_BITS - 6'h01)
        else $error("Time-out raised at the wrong count.");

    // An enabled raw condition reaches the interrupt line next cycle.
    intr_follow_a: assert property (
        |(raw & s.irq_mask) |=> INTR) else $error("Interrupt missing.");

    // A clear without a new event drops the overrun flag.
    overrun_clear_a: assert property (
        WR && ADDR == ADDR_CLEAR && WDATA[IRQ_OVR] && !overrun_set
        |=> !s.overrun) else $error("Overrun not cleared.");

    // A data write into a non-empty queue below full adds one word to it.
    tx_push_a: assert property (
        wr_data && txq_count != '0 && txq_count != QUEUE_FULL && !txq_pop
        |=> txq_count == $past(txq_count) + CNT_ONE)
        else $error("Data write not queued.");

    // A data write into a full queue is dropped.
    full_write_drop_a: assert property (
        wr_data && txq_count == QUEUE_FULL && !txq_pop
        |=> txq_count == QUEUE_FULL)
        else $error("Write into a full queue changed its level.");

    // When the offered word is taken, the queue head follows it.
    tx_queue_order_a: assert property (
        TX_TAKE && s.tx_out.valid && txq_count != '0
        |=> TX_WORD.valid && TX_WORD.data == $past(txq_dout))
        else $error("Queued word not offered in order.");

    // A data read removes one frame from a non-empty receive queue.
    rx_pop_a: assert property (
        rd_data && rxq_count != '0 && !RX_FRAME.strobe
        |=> rxq_count == $past(rxq_count) - CNT_ONE)
        else $error("Data read did not remove a frame.");

    // A divisor write keeps every bit but the lowest.
    prescale_write_a: assert property (
        WR && ADDR == ADDR_PRESCALE
        |=> s.prescale_divisor == ($past(WDATA[7:0]) & PRESCALE_MASK))
        else $error("Divisor write not taken.");

    // Overrun stays set until software clears it.
    overrun_sticky_a: assert property (
        s.overrun && !(WR && ADDR == ADDR_CLEAR && WDATA[IRQ_OVR])
        |=> s.overrun) else $error("Overrun dropped without a clear.");

    // The receive half flag reads at four or more frames.
    rx_half_flag_a: assert property (
        RD && ADDR == ADDR_RAW
        |=> RDATA[IRQ_RXH] == ($past(rxq_count) >= QUEUE_HALF))
        else $error("Receive half flag wrong.");

    // The transmit half flag reads at four or fewer words.
    tx_half_flag_a: assert property (
        RD && ADDR == ADDR_RAW
        |=> RDATA[IRQ_TXH] == ($past(txq_count) <= QUEUE_HALF))
        else $error("Transmit half flag wrong.");

    // No enabled condition keeps the interrupt line low.
    intr_quiet_a: assert property (
        (raw & s.irq_mask) == '0 |=> !INTR)
        else $error("Interrupt without an enabled condition.");

    // A clear without a new event drops the time-out flag.
    timeout_clear_a: assert property (
        WR && ADDR == ADDR_CLEAR && WDATA[IRQ_TMO] && !timeout_set
        |=> !s.rx_timeout) else $error("Time-out not cleared.");
endmodule

// ### src/sfsir_pkg.sv
// Shared constants and carrier types for the serial port register block.
package sfsir_pkg;
    // Data path and queue geometry.
    localparam int DW = 16;
    localparam int DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] QUEUE_FULL = 4'h8;
    localparam logic [CNT_W-1:0] QUEUE_HALF = 4'h4;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Register byte addresses.
    localparam logic [31:0] ADDR_DATA = 32'h4004_0008;
    localparam logic [31:0] ADDR_STATUS = 32'h4004_000c;
    localparam logic [31:0] ADDR_PRESCALE = 32'h4004_0010;
    localparam logic [31:0] ADDR_MASK = 32'h4004_0014;
    localparam logic [31:0] ADDR_RAW = 32'h4004_0018;
    localparam logic [31:0] ADDR_MASKED = 32'h4004_001c;
    localparam logic [31:0] ADDR_CLEAR = 32'h4004_0020;

    // Status bit positions.
    localparam int ST_TXE = 0;
    localparam int ST_TXNF = 1;
    localparam int ST_RXNE = 2;
    localparam int ST_RXF = 3;
    localparam int ST_ACT = 4;

    // Interrupt condition bit positions.
    localparam int IRQ_OVR = 0;
    localparam int IRQ_TMO = 1;
    localparam int IRQ_RXH = 2;
    localparam int IRQ_TXH = 3;

    // Reset values, divider limits and the receive time-out length.
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_MIN = 8'h02;
    localparam logic [7:0] PRESCALE_MASK = 8'hfe;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [DW-1:0] DATA_RESET = 16'h0000;
    localparam logic [5:0] TIMEOUT_BITS = 6'h20;

    // Frame handed to the shifter and frame returned by it.
    typedef struct packed {
        logic [DW-1:0] data;
        logic valid;
    } sfsir_tx_word_t;

    typedef struct packed {
        logic [DW-1:0] data;
        logic strobe;
    } sfsir_rx_frame_t;

    // Queue state.
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [PTR_W-1:0] wptr;
        logic [PTR_W-1:0] rptr;
        logic [CNT_W-1:0] count;
    } sfsir_queue_st_t;

    // Bit clock divider state.
    typedef struct packed {
        logic [7:0] pre_cnt;
        logic [7:0] rate_cnt;
        logic tick;
    } sfsir_div_st_t;

    // Register block state.
    typedef struct packed {
        logic [7:0] prescale_divisor;
        logic [3:0] irq_mask;
        logic overrun;
        logic rx_timeout;
        logic [5:0] to_cnt;
        sfsir_tx_word_t tx_out;
        logic [31:0] rdata;
        logic intr;
    } sfsir_st_t;
endpackage

// ### src/sfsir_queue.sv
// Eight-entry word queue; a push into a full queue replaces the newest word.
`timescale 1ns/1ps
module sfsir_queue (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Push side.
    input wire logic push,
    input wire logic [sfsir_pkg::DW-1:0] din,
    // Pop side.
    input wire logic pop,
    output logic [sfsir_pkg::DW-1:0] dout,
    output logic [sfsir_pkg::CNT_W-1:0] count
);
    import sfsir_pkg::*;

    sfsir_queue_st_t s;
    sfsir_queue_st_t next_s;
    logic do_pop;
    logic room;

    // Head word and fill level are read straight from the state.
    assign dout = s.mem[s.rptr];
    assign count = s.count;
    assign do_pop = pop && (s.count != '0);
    assign room = (s.count != QUEUE_FULL) || do_pop;

    // Next state: pushes append, or overwrite the newest entry when full.
    always_comb begin
        next_s = s;
        if (push && room) begin
            next_s.mem[s.wptr] = din;
            next_s.wptr = s.wptr + PTR_ONE;
        end else if (push) begin
            next_s.mem[s.wptr - PTR_ONE] = din;
        end
        if (do_pop) begin
            next_s.rptr = s.rptr + PTR_ONE;
        end
        if (push && room && !do_pop) begin
            next_s.count = s.count + CNT_ONE;
        end else if (do_pop && !(push && room)) begin
            next_s.count = s.count - CNT_ONE;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The fill level never passes the depth.
    queue_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        s.count <= QUEUE_FULL) else $error("Queue level above depth.");
endmodule

// ### src/sfsir_bitclk.sv
// Two-stage divider making the one-cycle bit clock enable.
`timescale 1ns/1ps
module sfsir_bitclk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Division factors.
    input wire logic [7:0] prescale_divisor,
    input wire logic [7:0] serial_clock_rate_factor,
    // Bit clock enable.
    output logic tick
);
    import sfsir_pkg::*;

    sfsir_div_st_t s;
    sfsir_div_st_t next_s;
    logic [7:0] pre_lim;

    // A divisor below the minimum is run at the minimum.
    assign pre_lim = ((prescale_divisor < PRESCALE_MIN) ? PRESCALE_MIN
        : prescale_divisor) - 8'h01;
    assign tick = s.tick;

    // Prescaler first, then the rate counter on each prescaler output.
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.pre_cnt >= pre_lim) begin
            next_s.pre_cnt = '0;
            if (s.rate_cnt >= serial_clock_rate_factor) begin
                next_s.rate_cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.rate_cnt = s.rate_cnt + 8'h01;
            end
        end else begin
            next_s.pre_cnt = s.pre_cnt + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // The divisor is at least two, so ticks never touch.
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick) else $error("Bit ticks back to back.");
endmodule

// ### tb/sfsir_shifter_model.sv
// Behavioural model of the frame shifter beyond the block.
`timescale 1ns/1ps
module sfsir_shifter_model #(
    parameter int FRAME_TICKS = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Test control.
    input wire logic stall,
    // Link to the block.
    input wire sfsir_pkg::sfsir_tx_word_t tx_word,
    output logic tx_take,
    output sfsir_pkg::sfsir_rx_frame_t rx_frame,
    output logic shift_active,
    input wire logic bit_tick
);
    import sfsir_pkg::*;
    logic [DW-1:0] hold;
    int ticks;
    logic [DW-1:0] sent_q[$];

    // Takes one word, shifts it for a fixed count of bit periods paced
    // by the block, then returns its inverse as the received frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_take <= 1'b0;
            rx_frame <= '0;
            shift_active <= 1'b0;
            hold <= '0;
            ticks <= 0;
        end else begin
            tx_take <= 1'b0;
            rx_frame.strobe <= 1'b0;
            rx_frame.data <= ~rx_frame.data; // Idle data never looks valid.
            if (tx_take) begin
                hold <= tx_word.data;
                sent_q.push_back(tx_word.data);
                shift_active <= 1'b1;
                ticks <= 0;
            end else if (shift_active && bit_tick) begin
                if (ticks == FRAME_TICKS - 1) begin
                    shift_active <= 1'b0;
                    rx_frame.strobe <= 1'b1;
                    rx_frame.data <= ~hold;
                end else begin
                    ticks <= ticks + 1;
                end
            end else if (!shift_active && !stall && tx_word.valid) begin
                tx_take <= 1'b1;
            end
        end
    end
endmodule

// ### tb/spi_fifo_status_irq_regs_tb.sv
// Self-checking testbench for the serial port register block.
`timescale 1ns/1ps
module spi_fifo_status_irq_regs_tb;
    import sfsir_pkg::*;
    logic mclk, reset_n, wr, rd, stall, bit_tick, tx_take, shift_active;
    logic intr;
    logic [31:0] addr, wdata, rdata;
    logic [7:0] rate;
    logic [3:0] frame_m1;
    sfsir_tx_word_t tx_word;
    sfsir_rx_frame_t rx_frame;
    int n_fail, n_tests;
    logic [15:0] w[9];

    sfsir_top dut(.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SERIAL_CLOCK_RATE_FACTOR(rate), .FRAME_BITS_M1(frame_m1),
        .TX_WORD(tx_word), .TX_TAKE(tx_take), .RX_FRAME(rx_frame),
        .SHIFT_ACTIVE(shift_active), .BIT_TICK(bit_tick), .INTR(intr));
    sfsir_shifter_model #(.FRAME_TICKS(8)) peer(.clk(mclk),
        .rst_n(reset_n), .stall(stall), .tx_word(tx_word),
        .tx_take(tx_take), .rx_frame(rx_frame),
        .shift_active(shift_active), .bit_tick(bit_tick));

    // Clock of 40 ns period.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Counts a comparison and reports a mismatch.
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A bound ran out: count it and stop.
    task automatic give_up;
        n_fail++;
        finish_test();
    endtask

    // Register bus cycles.
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic expect_reg(input string name, input logic [31:0] a,
                              input logic [31:0] exp);
        logic [31:0] d;
        bus_read(a, d);
        check(name, d, exp);
    endtask

    // Waits for a number of bit clock pulses.
    task automatic wait_ticks(input int n);
        int seen;
        seen = 0;
        for (int i = 0; i < 4000 && seen < n; i++) begin
            @(posedge mclk);
            #1;
            if (bit_tick === 1'b1) seen++;
        end
        if (seen < n) give_up();
    endtask

    // Reset values and an unmapped read.
    task automatic t_reset;
        expect_reg("status", ADDR_STATUS, 32'h3);
        expect_reg("prescale", ADDR_PRESCALE, 32'h0);
        expect_reg("mask", ADDR_MASK, 32'h0);
        expect_reg("raw", ADDR_RAW, 32'h8);
        expect_reg("unmapped", 32'h4004_0030, 32'h0);
        check("intr", {31'h0, intr}, 32'h0);
    endtask

    // Divisor low bit, mask width and a write to the status register.
    task automatic t_regs;
        bus_write(ADDR_PRESCALE, 32'hffff_ffff);
        expect_reg("prescale odd", ADDR_PRESCALE, 32'hfe);
        bus_write(ADDR_MASK, 32'hffff_ffff);
        expect_reg("mask all", ADDR_MASK, 32'hf);
        bus_write(ADDR_MASK, 32'h0);
        bus_write(ADDR_STATUS, 32'h0);
        expect_reg("status ro", ADDR_STATUS, 32'h3);
    endtask

    // Bit period for several divisor and rate pairs; ends at 12 cycles.
    task automatic t_bit_clock;
        logic [7:0] div[3] = '{8'h02, 8'h06, 8'h04};
        logic [7:0] fac[3] = '{8'h07, 8'h01, 8'h02};
        int per[3] = '{16, 12, 12};
        int cnt;
        for (int k = 0; k < 3; k++) begin
            bus_write(ADDR_PRESCALE, {24'h0, div[k]});
            rate <= fac[k];
            wait_ticks(2);
            cnt = 0;
            for (int i = 0; i < 600; i++) begin
                @(posedge mclk);
                #1 cnt++;
                if (bit_tick === 1'b1) break;
            end
            check("bit period", cnt, per[k]);
        end
    endtask

    // Fill the transmit side while stalled, then drain both directions.
    task automatic t_tx_fill;
        logic [31:0] s;
        logic [15:0] e;
        for (int i = 0; i < 9; i++) w[i] = 16'h00a0 + 16'(i);
        bus_write(ADDR_DATA, {16'h0, w[0]});
        #1 check("tx word", {15'h0, tx_word}, {15'h0, w[0], 1'b1});
        for (int i = 1; i < 9; i++) bus_write(ADDR_DATA, {16'h0, w[i]});
        expect_reg("status tx full", ADDR_STATUS, 32'h10);
        expect_reg("raw tx full", ADDR_RAW, 32'h0);
        bus_write(ADDR_DATA, 32'h0000_00ee);
        stall <= 1'b0;
        for (int i = 0; i < 1000; i++) begin
            bus_read(ADDR_STATUS, s);
            if (s[ST_ACT] === 1'b0) break;
            if (i == 999) give_up();
        end
        check("sent count", peer.sent_q.size(), 9);
        for (int i = 0; i < 9; i++) check("sent", peer.sent_q[i], w[i]);
        expect_reg("status rx full", ADDR_STATUS, 32'hf);
        expect_reg("raw rx full", ADDR_RAW, 32'hf);
        check("intr masked", {31'h0, intr}, 32'h0);
        bus_write(ADDR_MASK, 32'h1);
        expect_reg("masked", ADDR_MASKED, 32'h1);
        check("intr ovr", {31'h0, intr}, 32'h1);
        bus_write(ADDR_CLEAR, 32'h1);
        expect_reg("raw clr", ADDR_RAW, 32'he);
        check("intr clr", {31'h0, intr}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            e = (i < 7) ? w[i] : w[8];
            expect_reg("rx data", ADDR_DATA, {24'h0, ~e[7:0]});
        end
        expect_reg("status empty", ADDR_STATUS, 32'h3);
        bus_write(ADDR_CLEAR, 32'h2);
        expect_reg("raw empty", ADDR_RAW, 32'h8);
        bus_write(ADDR_MASK, 32'h0);
    endtask

    // One unread frame raises the time-out after 32 bit periods; it is
    // then read back as a 12-bit frame.
    task automatic t_timeout;
        bus_write(ADDR_MASK, 32'h2);
        frame_m1 <= 4'hb;
        bus_write(ADDR_DATA, 32'h0000_0055);
        for (int i = 0; i < 2000; i++) begin
            @(posedge mclk);
            #1;
            if (rx_frame.strobe === 1'b1) break;
            if (i == 1999) give_up();
        end
        wait_ticks(24);
        expect_reg("raw early", ADDR_RAW, 32'h8);
        check("intr early", {31'h0, intr}, 32'h0);
        wait_ticks(12);
        expect_reg("raw late", ADDR_RAW, 32'ha);
        check("intr late", {31'h0, intr}, 32'h1);
        expect_reg("rx data", ADDR_DATA, 32'hfaa);
        bus_write(ADDR_CLEAR, 32'h2);
        expect_reg("raw clr", ADDR_RAW, 32'h8);
        check("intr clr", {31'h0, intr}, 32'h0);
    endtask

    // Main sequence.
    initial begin
        n_fail = 0;
        n_tests = 0;
        reset_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        rate = 8'h02;
        frame_m1 = 4'h7;
        stall = 1'b1;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_bit_clock();
        t_tx_fill();
        t_timeout();
        finish_test();
    end
endmodule
